// [pkg/dac_host_pkg.sv]
// constants shared by the dual converter host controller
`default_nettype none
package dac_host_pkg;
   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CODE_A_OFS = 8'h04;
   localparam logic [7:0] CODE_B_OFS = 8'h08;
   localparam logic [7:0] CMD_OFS    = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // ------------------------------------------------------------------
   // control register fields and reset value
   // ------------------------------------------------------------------
   localparam int CTRL_BYTE_MODE  = 0;
   localparam int CTRL_SYNC_MODE  = 1;
   localparam int CTRL_SLEEP      = 2;
   localparam int CTRL_RANGE_DBL  = 3;
   localparam int CTRL_REF_BUF    = 4;
   localparam int CTRL_W          = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   // ------------------------------------------------------------------
   // command register bits (write one to request)
   // ------------------------------------------------------------------
   localparam int CMD_WRITE_A = 0;
   localparam int CMD_WRITE_B = 1;
   localparam int CMD_LOAD    = 2;
   localparam int CMD_CLEAR   = 3;
   // ------------------------------------------------------------------
   // status register bits
   // ------------------------------------------------------------------
   localparam int STAT_BUSY   = 0;
   localparam int STAT_WAKING = 1;
   localparam int STAT_ASLEEP = 2;
   // ------------------------------------------------------------------
   // code and bus layout
   // ------------------------------------------------------------------
   localparam int CODE_W    = 12;
   localparam int BUS_W     = 16;
   localparam int WORD_GAIN = 12;
   localparam int WORD_BUF  = 13;
   localparam int HI_GAIN   = 4;
   localparam int HI_BUF    = 5;
   localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------------
   // timing: figures in ns, counts derived at the 50 MHz clock
   // ------------------------------------------------------------------
   localparam int CLK_NS      = 20;
   localparam int T_SETUP_NS  = 20;
   localparam int T_STROBE_NS = 40;
   localparam int T_HOLD_NS   = 20;
   localparam int T_LOAD_NS   = 40;
   localparam int T_CLEAR_NS  = 40;
   localparam int T_WAKE_NS   = 5000;
   localparam int TMR_W       = 8;
   localparam logic [TMR_W-1:0] SETUP_CYC  =
      TMR_W'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] STROBE_CYC =
      TMR_W'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] HOLD_CYC   =
      TMR_W'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] LOAD_CYC   =
      TMR_W'((T_LOAD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] CLEAR_CYC  =
      TMR_W'((T_CLEAR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] WAKE_CYC   =
      TMR_W'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);
   // ------------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_CLEAR, S_SETUP, S_STROBE, S_HOLD, S_LOAD
   } seq_state_e;
endpackage : dac_host_pkg
`default_nettype wire

// [design/phase_timer.sv]
// down counter that times one phase of a pin sequence
`default_nettype none
module phase_timer #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // control
   input  wire logic         start,
   input  wire logic [W-1:0] cycles,
   // result
   output logic              done
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // start loads cycles-1 so the phase lasts exactly cycles clocks
   assign cnt_next = start ? cycles - W'(1)
                   : (cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
   assign done     = (cnt_reg == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) cnt_reg <= '0;
      else          cnt_reg <= cnt_next;
   end
endmodule : phase_timer
`default_nettype wire

// [design/dac_host.sv]
// host controller that drives a dual converter over its parallel pins
// What this block does
// - lines above the code carry range and reference option bits
// - outside sync mode, host writes both channels with load high, then pulses load once
// - byte variant: host writes both bytes before pulsing load
// - word bus must be wide enough to hold the option bits
`default_nettype none
module dac_host (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // converter pins
   output logic             device_select_n,
   output logic             store_strobe_n,
   output logic             channel_sel,
   output logic             upper_byte_sel,
   output logic [15:0]      data_bus,
   output logic             output_load_n,
   output logic             async_clear_n,
   output logic             sleep_n
);
   // ------------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------------
   logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [dac_host_pkg::CTRL_W-1:0] ctrl_reg;
   logic [dac_host_pkg::CODE_W-1:0] code_a_reg, code_b_reg;
   wire wr_go  = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
   wire wr_do  = awready_reg;
   wire rd_go  = arvalid & ~arready_reg & ~rvalid_reg;
   wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                        {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire w_ctrl = wr_do & (awaddr == dac_host_pkg::CTRL_OFS);
   wire w_ca   = wr_do & (awaddr == dac_host_pkg::CODE_A_OFS);
   wire w_cb   = wr_do & (awaddr == dac_host_pkg::CODE_B_OFS);
   wire w_cmd  = wr_do & (awaddr == dac_host_pkg::CMD_OFS) & wstrb[0];
   // the map is word aligned and ends at the status word
   wire w_hit  = (awaddr[1:0] == 2'h0)
               & (awaddr <= dac_host_pkg::STATUS_OFS);
   wire r_hit  = (araddr[1:0] == 2'h0)
               & (araddr <= dac_host_pkg::STATUS_OFS);
   wire [31:0] ctrl_wide = {27'h0, ctrl_reg};
   wire [31:0] ca_wide   = {20'h0, code_a_reg};
   wire [31:0] cb_wide   = {20'h0, code_b_reg};
   wire [31:0] ctrl_mrg  = (ctrl_wide & ~wmask) | (wdata & wmask);
   wire [31:0] ca_mrg    = (ca_wide & ~wmask) | (wdata & wmask);
   wire [31:0] cb_mrg    = (cb_wide & ~wmask) | (wdata & wmask);
   // ------------------------------------------------------------------
   // sequencer state and pending requests
   // ------------------------------------------------------------------
   dac_host_pkg::seq_state_e state_reg, state_next;
   logic pend_a_reg, pend_b_reg, pend_load_reg, pend_clear_reg;
   logic ch_reg, ch_next, hi_reg, hi_next;
   logic step_done, wake_done, tmr_start;
   logic [dac_host_pkg::TMR_W-1:0] tmr_cycles;
   logic sleep_prev_reg;
   wire byte_mode = ctrl_reg[dac_host_pkg::CTRL_BYTE_MODE];
   wire sync_mode = ctrl_reg[dac_host_pkg::CTRL_SYNC_MODE];
   wire sleeping  = ctrl_reg[dac_host_pkg::CTRL_SLEEP];
   wire range_dbl = ctrl_reg[dac_host_pkg::CTRL_RANGE_DBL];
   wire ref_buf   = ctrl_reg[dac_host_pkg::CTRL_REF_BUF];
   wire busy      = (state_reg != dac_host_pkg::S_IDLE) | pend_a_reg
                  | pend_b_reg | pend_load_reg | pend_clear_reg;
   // a channel code is finished after its last byte's hold phase
   wire code_fin  = (state_reg == dac_host_pkg::S_HOLD) & step_done
                  & (~byte_mode | hi_reg);
   wire take_a    = code_fin & ~ch_reg;
   wire take_b    = code_fin & ch_reg;
   wire take_load = (state_reg == dac_host_pkg::S_LOAD) & step_done;
   wire take_clr  = (state_reg == dac_host_pkg::S_CLEAR) & step_done;
   // new request wins over the consume in the same cycle
   wire pend_a_next   = (pend_a_reg & ~take_a)
                      | (w_cmd & wdata[dac_host_pkg::CMD_WRITE_A]);
   wire pend_b_next   = (pend_b_reg & ~take_b)
                      | (w_cmd & wdata[dac_host_pkg::CMD_WRITE_B]);
   wire pend_ld_next  = (pend_load_reg & ~take_load)
                      | (w_cmd & wdata[dac_host_pkg::CMD_LOAD]);
   wire pend_clr_next = (pend_clear_reg & ~take_clr)
                      | (w_cmd & wdata[dac_host_pkg::CMD_CLEAR]);
   always_comb begin
      state_next = state_reg;
      ch_next    = ch_reg;
      hi_next    = hi_reg;
      tmr_cycles = dac_host_pkg::SETUP_CYC;
      case (state_reg)
         dac_host_pkg::S_IDLE: begin
            if (pend_clear_reg) begin
               state_next = dac_host_pkg::S_CLEAR;
               tmr_cycles = dac_host_pkg::CLEAR_CYC;
               hi_next    = 1'b0;
            end else if (pend_a_reg | pend_b_reg) begin
               // finish the channel whose high byte is outstanding
               if (!hi_reg) ch_next = ~pend_a_reg;
               state_next = dac_host_pkg::S_SETUP;
            end else if (pend_load_reg) begin
               // load only after every queued write is out
               state_next = dac_host_pkg::S_LOAD;
               tmr_cycles = dac_host_pkg::LOAD_CYC;
            end
         end
         dac_host_pkg::S_SETUP: begin
            tmr_cycles = dac_host_pkg::STROBE_CYC;
            if (step_done) state_next = dac_host_pkg::S_STROBE;
         end
         dac_host_pkg::S_STROBE: begin
            tmr_cycles = dac_host_pkg::HOLD_CYC;
            if (step_done) state_next = dac_host_pkg::S_HOLD;
         end
         dac_host_pkg::S_HOLD: begin
            if (step_done) begin
               state_next = dac_host_pkg::S_IDLE;
               hi_next    = byte_mode & ~hi_reg;
            end
         end
         dac_host_pkg::S_LOAD,
         dac_host_pkg::S_CLEAR: begin
            if (step_done) state_next = dac_host_pkg::S_IDLE;
         end
         default: state_next = dac_host_pkg::S_IDLE;
      endcase
   end
   assign tmr_start = (state_next != state_reg);
   // ------------------------------------------------------------------
   // pin values
   // ------------------------------------------------------------------
   wire in_write = (state_reg == dac_host_pkg::S_SETUP)
                 | (state_reg == dac_host_pkg::S_STROBE)
                 | (state_reg == dac_host_pkg::S_HOLD);
   wire [11:0] code = ch_reg ? code_b_reg : code_a_reg;
   wire [15:0] word_bus = {2'h0, ref_buf, range_dbl, code};
   wire [15:0] lo_bus   = {8'h00, code[7:0]};
   wire [15:0] hi_bus   = {8'h00, 2'h0, ref_buf, range_dbl,
                           code[11:8]};
   wire [15:0] bus_next = ~in_write ? data_bus
                        : ~byte_mode ? word_bus
                        : hi_reg ? hi_bus : lo_bus;
   // synchronous mode keeps load low so each strobe rise updates
   wire load_n_next = ~(sync_mode
                      | (state_reg == dac_host_pkg::S_LOAD));
   wire wake_start  = sleep_prev_reg & ~sleeping;
   // ------------------------------------------------------------------
   // timers
   // ------------------------------------------------------------------
   phase_timer #(.W(dac_host_pkg::TMR_W)) step_tmr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (tmr_start),
      .cycles  (tmr_cycles),
      .done    (step_done)
   );
   phase_timer #(.W(dac_host_pkg::TMR_W)) wake_tmr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (wake_start),
      .cycles  (dac_host_pkg::WAKE_CYC),
      .done    (wake_done)
   );
   wire [31:0] status_wide = {29'h0, sleeping, ~wake_done, busy};
   wire [31:0] rd_mux =
      (araddr == dac_host_pkg::CTRL_OFS)   ? ctrl_wide :
      (araddr == dac_host_pkg::CODE_A_OFS) ? ca_wide :
      (araddr == dac_host_pkg::CODE_B_OFS) ? cb_wide :
      (araddr == dac_host_pkg::STATUS_OFS) ? status_wide : 32'h0;
   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= dac_host_pkg::RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= dac_host_pkg::RESP_OKAY;
         rdata_reg   <= 32'h0;
      end else begin
         awready_reg <= wr_go;
         wready_reg  <= wr_go;
         arready_reg <= rd_go;
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= w_hit ? dac_host_pkg::RESP_OKAY
                                : dac_host_pkg::RESP_SLVERR;
         end else if (bready) bvalid_reg <= 1'b0;
         if (arready_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= r_hit ? dac_host_pkg::RESP_OKAY
                                : dac_host_pkg::RESP_SLVERR;
         end else if (rready) rvalid_reg <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= dac_host_pkg::CTRL_RESET;
         code_a_reg <= dac_host_pkg::CODE_RESET;
         code_b_reg <= dac_host_pkg::CODE_RESET;
      end else begin
         if (w_ctrl) ctrl_reg <= ctrl_mrg[dac_host_pkg::CTRL_W-1:0];
         if (w_ca) code_a_reg <= ca_mrg[dac_host_pkg::CODE_W-1:0];
         if (w_cb) code_b_reg <= cb_mrg[dac_host_pkg::CODE_W-1:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= dac_host_pkg::S_IDLE;
         ch_reg         <= 1'b0;
         hi_reg         <= 1'b0;
         pend_a_reg     <= 1'b0;
         pend_b_reg     <= 1'b0;
         pend_load_reg  <= 1'b0;
         pend_clear_reg <= 1'b0;
         sleep_prev_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         ch_reg         <= ch_next;
         hi_reg         <= hi_next;
         pend_a_reg     <= pend_a_next;
         pend_b_reg     <= pend_b_next;
         pend_load_reg  <= pend_ld_next;
         pend_clear_reg <= pend_clr_next;
         sleep_prev_reg <= sleeping;
      end
   end

   // pins follow the sequencer state one clock later; sleep_n follows the sleep bit, and load is also held low by sync mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         device_select_n <= 1'b1;
         store_strobe_n  <= 1'b1;
         channel_sel     <= 1'b0;
         upper_byte_sel  <= 1'b0;
         data_bus        <= 16'h0000;
         output_load_n   <= 1'b1;
         async_clear_n   <= 1'b1;
         sleep_n         <= 1'b1;
      end else begin
         device_select_n <= ~in_write;
         store_strobe_n  <= ~(state_reg == dac_host_pkg::S_STROBE);
         if (in_write) channel_sel <= ch_reg;
         if (in_write) upper_byte_sel <= byte_mode & hi_reg;
         data_bus        <= bus_next;
         output_load_n   <= load_n_next;
         async_clear_n   <= ~(state_reg == dac_host_pkg::S_CLEAR);
         sleep_n         <= ~sleeping;
      end
   end
   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;
endmodule : dac_host
`default_nettype wire

// [bench/dac_model.sv]
// behavioural model of the dual converter's parallel load logic
`default_nettype none
module dac_model (
   // parallel pins
   input  wire logic        device_select_n,
   input  wire logic        store_strobe_n,
   input  wire logic        channel_sel,
   input  wire logic        upper_byte_sel,
   input  wire logic [15:0] data_bus,
   input  wire logic        output_load_n,
   input  wire logic        async_clear_n,
   input  wire logic        sleep_n,
   input  wire logic        byte_mode,
   // contents as {buffered ref, double range, code}
   output logic      [13:0] in_a,
   output logic      [13:0] in_b,
   output logic      [13:0] dac_a,
   output logic      [13:0] dac_b,
   output wire logic        asleep
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        chg_a;
   logic        chg_b;
   logic [13:0] nxt;
   initial begin
      in_a = 14'h0000;
      in_b = 14'h0000;
      dac_a = 14'h0000;
      dac_b = 14'h0000;
      chg_a = 1'b0;
      chg_b = 1'b0;
   end
   // outputs open while asleep, registers untouched
   assign asleep = !sleep_n;
   always @(posedge store_strobe_n) begin
      if (!device_select_n && async_clear_n) begin
         nxt = channel_sel ? in_b : in_a;
         if (!byte_mode) nxt = data_bus[13:0];
         else if (!upper_byte_sel) nxt[7:0] = data_bus[7:0];
         else nxt[13:8] = data_bus[5:0];
         if (channel_sel) in_b = nxt;
         else in_a = nxt;
         if (channel_sel) chg_b = 1'b1;
         else chg_a = 1'b1;
      end
   end
   always @(output_load_n, chg_a, chg_b, async_clear_n) begin
      if (!async_clear_n) begin
         {in_a, in_b, dac_a, dac_b} = 56'h0;
         {chg_a, chg_b} = 2'h0;
      end else if (!output_load_n) begin
         if (chg_a) dac_a = in_a;
         if (chg_b) dac_b = in_b;
         {chg_a, chg_b} = 2'h0;
      end
   end
endmodule : dac_model
`default_nettype wire

// [bench/dac_host_assertions.sv]
// pin timing checks for the converter host controller
`default_nettype none
module dac_host_assertions (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // converter pins
   input wire logic        device_select_n,
   input wire logic        store_strobe_n,
   input wire logic        channel_sel,
   input wire logic        upper_byte_sel,
   input wire logic [15:0] data_bus,
   input wire logic        output_load_n,
   input wire logic        async_clear_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence low_two(s);
      !s [*2] ##1 s;
   endsequence
   sequence then_high(s);
      !s ##1 s;
   endsequence
   strobe_needs_select_a: assert property (
      !store_strobe_n |-> !device_select_n)
      else $error("strobe low while deselected");
   strobe_width_a: assert property (
      $fell(store_strobe_n) |-> low_two(store_strobe_n))
      else $error("strobe pulse not two cycles");
   select_setup_a: assert property (
      $fell(device_select_n) |=> $fell(store_strobe_n))
      else $error("strobe did not follow select");
   select_hold_a: assert property (
      $rose(store_strobe_n) |-> then_high(device_select_n))
      else $error("select hold wrong");
   bus_stable_a: assert property (
      !device_select_n && !$past(device_select_n) |->
         $stable({data_bus, channel_sel, upper_byte_sel}))
      else $error("bus moved during select");
   clear_width_a: assert property (
      $fell(async_clear_n) |-> low_two(async_clear_n))
      else $error("clear pulse not two cycles");
   clear_idle_a: assert property (
      !async_clear_n |-> device_select_n)
      else $error("write during clear");
   load_after_write_a: assert property (
      $fell(output_load_n) |-> device_select_n)
      else $error("load during a write");
endmodule : dac_host_assertions
bind dac_host dac_host_assertions dac_host_assertions_inst (
   .aclk, .aresetn, .device_select_n, .store_strobe_n, .channel_sel,
   .upper_byte_sel, .data_bus, .output_load_n, .async_clear_n
);
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the dual converter host controller
`default_nettype none
`define CHK(nm, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      miscompares++; \
      $display("FAIL %s exp %h got %h", nm, e, g); \
   end \
end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, byte_mode = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, d;
   logic        device_select_n, store_strobe_n, channel_sel;
   logic        upper_byte_sel, output_load_n, async_clear_n, sleep_n;
   logic [15:0] data_bus;
   logic [13:0] in_a, in_b, dac_a, dac_b, eb, ea = 14'h0;
   logic [11:0] ca, cb;
   logic [4:0]  ctrl;
   wire         asleep;
   wire  [4:0]  ctl_pins = {device_select_n, store_strobe_n,
                             output_load_n, async_clear_n, sleep_n};
   int          miscompares = 0, cmp_count = 0, cycles = 0;
   always #10 aclk = ~aclk;
   dac_host dac_host_inst (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .device_select_n,
      .store_strobe_n, .channel_sel, .upper_byte_sel, .data_bus,
      .output_load_n, .async_clear_n, .sleep_n
   );
   dac_model dac_model_inst (
      .device_select_n, .store_strobe_n, .channel_sel, .upper_byte_sel,
      .data_bus, .output_load_n, .async_clear_n, .sleep_n, .byte_mode,
      .in_a, .in_b, .dac_a, .dac_b, .asleep
   );
   function automatic logic [13:0] exp_reg(logic [11:0] c, logic [4:0] k);
      return {k[dac_host_pkg::CTRL_REF_BUF],
              k[dac_host_pkg::CTRL_RANGE_DBL], c};
   endfunction : exp_reg
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while ((awvalid && awready !== 1'b1) ||
                 (wvalid && wready !== 1'b1));
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic settle();
      do rd(dac_host_pkg::STATUS_OFS);
      while (d[dac_host_pkg::STAT_BUSY] !== 1'b0);
   endtask : settle
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares = miscompares + 1;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(34571));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("pins", 5'h1f, ctl_pins)
      `CHK("dac a", 14'h0, dac_a)
      rd(dac_host_pkg::CTRL_OFS);
      `CHK("ctrl", 32'h0, d)
      for (int i = 0; i < 4; i++) begin
         ca = (i == 0) ? 12'hfff : 12'($urandom);
         cb = (i == 0) ? 12'h000 : 12'($urandom);
         ctrl = {2'($urandom), 3'h0};
         wr(dac_host_pkg::CTRL_OFS, 32'(ctrl));
         wr(dac_host_pkg::CODE_A_OFS, 32'(ca));
         wr(dac_host_pkg::CODE_B_OFS, 32'(cb));
         wr(dac_host_pkg::CMD_OFS, 32'h3);
         settle();
         `CHK("held a", ea, dac_a)
         ea = exp_reg(ca, ctrl);
         eb = exp_reg(cb, ctrl);
         `CHK("input a", ea, in_a)
         `CHK("input b", eb, in_b)
         wr(dac_host_pkg::CMD_OFS, 32'h4);
         settle();
         `CHK("dac a", ea, dac_a)
         `CHK("dac b", eb, dac_b)
      end
      byte_mode <= 1'b1;
      ctrl = 5'h19;
      ca = 12'($urandom);
      wr(dac_host_pkg::CTRL_OFS, 32'(ctrl));
      wr(dac_host_pkg::CODE_A_OFS, 32'(ca));
      wr(dac_host_pkg::CMD_OFS, 32'h1);
      settle();
      `CHK("held bytes", ea, dac_a)
      ea = exp_reg(ca, ctrl);
      `CHK("bytes a", ea, in_a)
      wr(dac_host_pkg::CMD_OFS, 32'h4);
      settle();
      `CHK("dac bytes", ea, dac_a)
      byte_mode <= 1'b0;
      ctrl = 5'h02;
      cb = 12'($urandom);
      wr(dac_host_pkg::CTRL_OFS, 32'(ctrl));
      wr(dac_host_pkg::CODE_B_OFS, 32'(cb));
      wr(dac_host_pkg::CMD_OFS, 32'h2);
      settle();
      eb = exp_reg(cb, ctrl);
      `CHK("sync b", eb, dac_b)
      wr(dac_host_pkg::CTRL_OFS, 32'h4);
      rd(dac_host_pkg::STATUS_OFS);
      `CHK("asleep", 1'b1, asleep)
      `CHK("stat asleep", 1'b1, d[dac_host_pkg::STAT_ASLEEP])
      `CHK("kept b", eb, dac_b)
      wr(dac_host_pkg::CTRL_OFS, 32'h0);
      rd(dac_host_pkg::STATUS_OFS);
      `CHK("waking", 1'b1, d[dac_host_pkg::STAT_WAKING])
      repeat (int'(dac_host_pkg::WAKE_CYC) + 4) @(posedge aclk);
      rd(dac_host_pkg::STATUS_OFS);
      `CHK("awake", 32'h0, d)
      wr(dac_host_pkg::CMD_OFS, 32'h8);
      settle();
      `CHK("cleared", 56'h0, {in_a, in_b, dac_a, dac_b})
      // both writes and the load in one command: writes must go out first
      ca = 12'($urandom);
      cb = 12'($urandom);
      wr(dac_host_pkg::CODE_A_OFS, 32'(ca));
      wr(dac_host_pkg::CODE_B_OFS, 32'(cb));
      wr(dac_host_pkg::CMD_OFS, 32'h7);
      settle();
      `CHK("joint a", exp_reg(ca, 5'h00), dac_a)
      `CHK("joint b", exp_reg(cb, 5'h00), dac_b)
      wr(8'h20, 32'hffff_ffff);
      `CHK("bresp", dac_host_pkg::RESP_SLVERR, r)
      rd(8'h20);
      `CHK("rresp", dac_host_pkg::RESP_SLVERR, r)
      rd(dac_host_pkg::CMD_OFS);
      `CHK("cmd read", 32'h0, d)
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
